// File: hdl/abwc_area_timing.sv
`timescale 1ns/10ps
`include "abwc_map.svh"


module abwc_area_timing #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic accReq,
  input wire logic accWrite,
  output logic accReady,
  output logic accDone,
  input wire logic extWaitN,
  output logic areaSelectN,
  output logic readStrobeN,
  output logic byteStrobeN
);
  import abwc_pkg::*;

  // ========================================================================
  // Declarations
  // ========================================================================
  logic [31:0] cfg_r, cfg_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wrFire, rdFire;
  logic waitMeta_r, waitSync_r;
  abwc_state_t state_r, state_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic isWrite_r, isWrite_nxt;
  logic mask_r, mask_nxt;
  logic [1:0] hold_r, hold_nxt;
  abwc_wait_t wait_r, wait_nxt;
  logic done_r, done_nxt;
  logic selN_r, selN_nxt;
  logic rdN_r, rdN_nxt;
  logic wrN_r, wrN_nxt;
  abwc_wait_t readWait, writeWait;
  logic [31:0] statusWord;

  abwc_wait_decode u_decode (
    .readCode(cfg_r[`ABWC_WR_MSB:`ABWC_WR_LSB]),
    .writeCode(cfg_r[`ABWC_WW_MSB:`ABWC_WW_LSB]),
    .readWait(readWait),
    .writeWait(writeWait)
  );

  // ========================================================================
  // AXI4-Lite slave
  // ========================================================================
  // Address and data are taken in the same cycle; a master holds both until then.
  assign wrFire = awvalid && wvalid && !bvalid_r;
  assign awready = wrFire;
  assign wready = wrFire;
  assign rdFire = arvalid && !rvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  assign statusWord = {28'h0000000, state_r, waitSync_r, state_r != ST_IDLE};

  always_comb begin
    cfg_nxt = cfg_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (wrFire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt = `ABWC_RESP_OKAY;
      if (awaddr == `ABWC_CFG_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb[b]) begin
            cfg_nxt[8*b +: 8] = wdata[8*b +: 8];
          end
        end
        // Unused positions never store, whatever software writes there.
        cfg_nxt = cfg_nxt & `ABWC_CFG_WMASK;
      end else if (awaddr != `ABWC_STAT_OFFSET) begin
        bresp_nxt = `ABWC_RESP_SLVERR;
      end
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rdFire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `ABWC_RESP_OKAY;
      if (araddr == `ABWC_CFG_OFFSET) begin
        rdata_nxt = cfg_r & `ABWC_CFG_WMASK;
      end else if (araddr == `ABWC_STAT_OFFSET) begin
        rdata_nxt = statusWord;
      end else begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `ABWC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= `ABWC_CFG_RESET;
      bvalid_r <= 1'b0;
      bresp_r <= `ABWC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `ABWC_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ========================================================================
  // External wait synchroniser
  // ========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitMeta_r <= 1'b0;
      waitSync_r <= 1'b0;
    end else begin
      waitMeta_r <= !extWaitN;
      waitSync_r <= waitMeta_r;
    end
  end

  // ========================================================================
  // Bus cycle sequencer
  // ========================================================================
  // One clk period is half a bus cycle, so half-cycle settings map onto whole clocks.
  // Settings are captured at the start of an access; a register write during an
  // access takes effect only on the next one.
  assign accReady = (state_r == ST_IDLE);
  assign accDone = done_r;
  assign areaSelectN = selN_r;
  assign readStrobeN = rdN_r;
  assign byteStrobeN = wrN_r;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    isWrite_nxt = isWrite_r;
    mask_nxt = mask_r;
    hold_nxt = hold_r;
    wait_nxt = wait_r;
    done_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (accReq) begin
          state_nxt = ST_SETUP;
          isWrite_nxt = accWrite;
          mask_nxt = cfg_r[`ABWC_WM_BIT];
          hold_nxt = cfg_r[`ABWC_HW_MSB:`ABWC_HW_LSB];
          wait_nxt = accWrite ? writeWait : readWait;
          cnt_nxt = 6'({cfg_r[`ABWC_SW_MSB:`ABWC_SW_LSB], 1'b0});
        end
      end
      ST_SETUP: begin
        if (cnt_r == 6'd0) begin
          state_nxt = ST_STROBE;
          cnt_nxt = 6'({wait_r, 1'b0}) + 6'd1;
        end else begin
          cnt_nxt = cnt_r - 6'd1;
        end
      end
      ST_STROBE: begin
        if (cnt_r != 6'd0) begin
          cnt_nxt = cnt_r - 6'd1;
        end else if (!mask_r && waitSync_r) begin
          state_nxt = ST_STROBE;
        end else begin
          state_nxt = ST_HOLD;
          cnt_nxt = 6'({hold_r, 1'b0});
        end
      end
      ST_HOLD: begin
        if (cnt_r == 6'd0) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 6'd1;
        end
      end
    endcase
    selN_nxt = (state_nxt == ST_IDLE);
    rdN_nxt = !((state_nxt == ST_STROBE) && !isWrite_nxt);
    wrN_nxt = !((state_nxt == ST_STROBE) && isWrite_nxt);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 6'd0;
      isWrite_r <= 1'b0;
      mask_r <= 1'b0;
      hold_r <= 2'b00;
      wait_r <= 5'd0;
      done_r <= 1'b0;
      selN_r <= 1'b1;
      rdN_r <= 1'b1;
      wrN_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      isWrite_r <= isWrite_nxt;
      mask_r <= mask_nxt;
      hold_r <= hold_nxt;
      wait_r <= wait_nxt;
      done_r <= done_nxt;
      selN_r <= selN_nxt;
      rdN_r <= rdN_nxt;
      wrN_r <= wrN_nxt;
    end
  end

  // ========================================================================
  // Checks
  // ========================================================================
  logic [5:0] stLen_r;
  logic [1:0] swAcc_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stLen_r <= 6'd0;
      swAcc_r <= 2'b00;
    end else begin
      stLen_r <= (state_nxt != state_r) ? 6'd1 : stLen_r + 6'd1;
      if (state_r == ST_IDLE && accReq) begin
        swAcc_r <= cfg_r[`ABWC_SW_MSB:`ABWC_SW_LSB];
      end
    end
  end

  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (reset)
    rvalid |-> (rdata[31:19] == 13'h0) && (rdata[15:13] == 3'h0))
    else $error("Unused register bits read back nonzero.");

  AST_WW_SAME: assert property (@(posedge clk) disable iff (reset)
    (cfg_r[`ABWC_WW_MSB:`ABWC_WW_LSB] == 3'h0) |-> (writeWait == readWait))
    else $error("Write wait code zero does not follow the read wait.");

  AST_WW_CODE: assert property (@(posedge clk) disable iff (reset)
    (cfg_r[`ABWC_WW_MSB:`ABWC_WW_LSB] != 3'h0)
    |-> (writeWait == 5'(cfg_r[`ABWC_WW_MSB:`ABWC_WW_LSB]) - 5'd1))
    else $error("Write wait count is not code minus one.");

  AST_SETUP_LEN: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_SETUP && state_nxt == ST_STROBE)
    |-> (stLen_r == 6'({swAcc_r, 1'b0}) + 6'd1))
    else $error("Setup delay does not match the setup code.");

  AST_WR_LOW: assert property (@(posedge clk) disable iff (reset)
    (cfg_r[`ABWC_WR_MSB:`ABWC_WR_LSB] <= 4'h6)
    |-> (readWait == 5'(cfg_r[`ABWC_WR_MSB:`ABWC_WR_LSB])))
    else $error("Read wait count differs from its code.");

  AST_WR_HIGH: assert property (@(posedge clk) disable iff (reset)
    (cfg_r[`ABWC_WR_MSB:`ABWC_WR_LSB] inside {4'h7, 4'h8, 4'h9, 4'ha})
    |-> (readWait == 5'({cfg_r[`ABWC_WR_MSB:`ABWC_WR_LSB], 1'b0}) - 5'd6))
    else $error("Long read wait count is wrong.");

  AST_EXT_WAIT: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STROBE && cnt_r == 6'd0 && !mask_r && waitSync_r)
    |=> (state_r == ST_STROBE) && !areaSelectN)
    else $error("External wait did not stretch the strobe.");

  AST_HOLD_LEN: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_HOLD && state_nxt == ST_IDLE)
    |-> (stLen_r == 6'({hold_r, 1'b0}) + 6'd1) ##1 (accDone && areaSelectN))
    else $error("Hold delay does not match the hold code.");

  AST_STROBE_LEN: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_STROBE && state_nxt == ST_HOLD && mask_r)
    |-> (stLen_r == 6'({wait_r, 1'b0}) + 6'd2))
    else $error("Strobe width is not one base cycle plus the wait count.");

endmodule

// File: hdl/abwc_map.svh
`ifndef ABWC_MAP_SVH
`define ABWC_MAP_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define ABWC_CFG_OFFSET 12'h000
`define ABWC_STAT_OFFSET 12'h004
`define ABWC_CFG_RESET 32'h0000_0500
`define ABWC_CFG_WMASK 32'h0007_1fc3

// ==========================================================================
// Field positions of the wait configuration register
// ==========================================================================
`define ABWC_WW_MSB 18
`define ABWC_WW_LSB 16
`define ABWC_SW_MSB 12
`define ABWC_SW_LSB 11
`define ABWC_WR_MSB 10
`define ABWC_WR_LSB 7
`define ABWC_WM_BIT 6
`define ABWC_HW_MSB 1
`define ABWC_HW_LSB 0

// ==========================================================================
// Bus answers and timing
// ==========================================================================
`define ABWC_RESP_OKAY 2'b00
`define ABWC_RESP_SLVERR 2'b10
`define ABWC_WAIT_RESERVED 5'd24

`endif

// File: hdl/abwc_pkg.sv
package abwc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b11,
    ST_HOLD = 2'b10
  } abwc_state_t;

  typedef logic [4:0] abwc_wait_t;

endpackage

// File: hdl/abwc_wait_decode.sv
`timescale 1ns/10ps
`include "abwc_map.svh"

module abwc_wait_decode (
  input wire logic [3:0] readCode,
  input wire logic [2:0] writeCode,
  output abwc_pkg::abwc_wait_t readWait,
  output abwc_pkg::abwc_wait_t writeWait
);
  import abwc_pkg::*;

  // ========================================================================
  // Read and write wait count decode
  // ========================================================================
  always_comb begin
    unique case (readCode)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: readWait = abwc_wait_t'(readCode);
      4'h7: readWait = 5'd8;
      4'h8: readWait = 5'd10;
      4'h9: readWait = 5'd12;
      4'ha: readWait = 5'd14;
      4'hb: readWait = 5'd18;
      // Prohibited codes fall back to a wait of 24, longer than any legal code gives, so a slow part stays safe.
      default: readWait = `ABWC_WAIT_RESERVED;
    endcase
    if (writeCode == 3'h0) begin
      writeWait = readWait;
    end else begin
      writeWait = abwc_wait_t'(writeCode - 3'h1);
    end
  end

endmodule

// File: testbench/abwc_area_timing_bench.sv
`timescale 1ns/10ps
module abwc_area_timing_bench;
  import abwc_pkg::*;
  typedef struct packed {logic atLeast; logic [24:0] v;} abwc_exp_t;
  logic clk, reset, awvalid, wvalid, bready, arvalid, rready, accReq, accWrite, extWaitN;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, cfg;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, accReady, accDone;
  logic areaSelectN, readStrobeN, byteStrobeN, wrSeen;
  logic [7:0] stall, uc, sc, hc;
  logic [33:0] regQ[$];
  abwc_exp_t accQ[$];
  abwc_exp_t e;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ph = 0;

  abwc_area_timing DUT (.clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .accReq, .accWrite, .accReady, .accDone, .extWaitN, .areaSelectN, .readStrobeN,
    .byteStrobeN);
  abwc_ext_mem partner (.clk, .areaSelectN, .stallCycles(stall), .extWaitN);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic int rdW(input int c);
    if (c <= 6) return c;
    if (c <= 10) return 2 * c - 6;
    return (c == 11) ? 18 : 24;
  endfunction

  task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] s);
    cmp_count++;
    if (ex !== s) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic results();
    // A note left on either queue means a result that never appeared.
    if (regQ.size() != 0 || accQ.size() != 0) begin
      miscompares++;
    end
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    regQ.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [33:0] ex);
    regQ.push_back(ex);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Expected lengths in clocks: setup, strobe, hold; a half bus cycle is one clock.
  task automatic acc(input logic w, input int sw, input int wt, input int hw, input logic st);
    accQ.push_back(abwc_exp_t'({st, w, 8'(2 * sw + 1), 8'(2 * wt + 2), 8'(2 * hw + 1)}));
    accReq <= 1'b1;
    accWrite <= w;
    do @(posedge clk); while (!accReady);
    accReq <= 1'b0;
    do @(posedge clk); while (!accDone);
  endtask

  // ==========================================================================
  // Result monitors
  // ==========================================================================
  always @(posedge clk) begin
    if (rvalid && rready) chk("read", regQ.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("wresp", regQ.pop_front(), {bresp, 32'h0});
  end

  always @(posedge clk) begin
    if (!areaSelectN) begin
      if (!readStrobeN || !byteStrobeN) begin
        ph = 2;
        sc++;
        wrSeen |= !byteStrobeN;
      end else if (ph >= 2) begin
        ph = 3;
        hc++;
      end else begin
        ph = 1;
        uc++;
      end
    end else if (ph != 0) begin
      e = accQ.pop_front();
      if (e.atLeast) chk("stretch", 34'd1, 34'(sc > e.v[15:8]));
      else chk("access", 34'(e.v), 34'({1'b0, wrSeen, uc, sc, hc}));
      ph = 0;
      uc = 0;
      sc = 0;
      hc = 0;
      wrSeen = 0;
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {uc, sc, hc, wrSeen} = '0;
    {awvalid, wvalid, bready, arvalid, rready, accReq, accWrite} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    stall = 8'h00;
    seed = 32'h8d3e;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    axr(12'h000, {2'b00, 32'h0000_0500});
    axw(12'h000, 32'h0007_1fc3, 2'b00);
    axr(12'h000, {2'b00, 32'h0007_1fc3});
    axw(12'h00c, 32'h0, 2'b10);
    axr(12'h008, 34'h2_0000_0000);
    axw(12'h004, 32'h0, 2'b00);
    axr(12'h004, {2'b00, 32'h0000_0000});
    axr(12'h000, {2'b00, 32'h0007_1fc3});
    for (int i = 0; i < 13; i++) begin
      seed = xs(seed);
      cfg = {13'h0, 3'(i), 3'h0, 2'(i), 4'(i), 1'b1, 4'h0, seed[1:0]};
      axw(12'h000, cfg, 2'b00);
      axr(12'h000, {2'b00, cfg});
      acc(1'b0, i % 4, rdW(i), cfg[1:0], 1'b0);
      acc(1'b1, i % 4, (i % 8) ? i % 8 - 1 : rdW(i), cfg[1:0], 1'b0);
    end
    // The stall starts early so the synchroniser delay cannot hide it from the strobe.
    stall <= 8'd12;
    axw(12'h000, 32'h0000_1840, 2'b00);
    acc(1'b0, 3, 0, 0, 1'b0);
    axw(12'h000, 32'h0000_1800, 2'b00);
    acc(1'b0, 3, 0, 0, 1'b1);
    stall <= 8'd0;
    repeat (4) @(posedge clk);
    results();
  end
endmodule

// File: testbench/abwc_ext_mem.sv
`timescale 1ns/10ps
// ==========================================================================
// External device on the area select
// ==========================================================================
module abwc_ext_mem (
  input wire logic clk,
  input wire logic areaSelectN,
  input wire logic [7:0] stallCycles,
  output logic extWaitN
);
  int cnt = 0;
  logic selD = 1'b1;
  // The wait line has a pull-up, so it reads high whenever the device is not selected.
  always @(posedge clk) begin
    selD <= areaSelectN;
    if (selD && !areaSelectN) begin
      cnt <= stallCycles;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign extWaitN = !(cnt > 0 && !areaSelectN);
endmodule
